// ==== src/msq_consts.vh ====
// constants for the program sequencer: addresses, vectors, sizes
`ifndef MSQ_CONSTS_VH
`define MSQ_CONSTS_VH
`define MSQ_PHASES 4
`define MSQ_PH_LAST 2'h3
`define MSQ_PH_FIRST 4'h1
`define MSQ_PC_MASK_S 12'h7ff
`define MSQ_PC_MASK_L 12'hfff
`define MSQ_VEC_RESET 12'h000
`define MSQ_VEC_EXT 12'h004
`define MSQ_VEC_TMR 12'h008
`define MSQ_VEC_ADC 12'h00c
`define MSQ_STK_DEPTH 3'h6
`define MSQ_STK_LAST 3'h5
`define MSQ_ADR_IND0 8'h00
`define MSQ_ADR_PTR0 8'h01
`define MSQ_ADR_IND1 8'h02
`define MSQ_ADR_PTR1 8'h03
`define MSQ_ADR_BANK 8'h04
`define MSQ_ADR_PCL 8'h06
`define MSQ_ADR_TABLE_POINTER 8'h07
`define MSQ_ADR_TABLE_HIGH_RESULT 8'h08
`define MSQ_RAM_LO 8'h28
`define MSQ_RAM_HI_S 8'he7
`define MSQ_B1_LO 8'h40
`define MSQ_B1_HI 8'h7f
`define MSQ_BANK_ONE 8'h01
`define MSQ_RST_BYTE 8'h00
`endif

// ==== src/msq_program_sequencer.v ====
// program sequencer: phases, pipeline, counter, stack, tables, data map
`include "msq_consts.vh"

// What this block does
// - four one-hot phases; an instruction cycle is four clocks
// - fetch of next word overlaps execution of the previous one
// - counter is 11 bits small variant, 12 bits large variant
// - counter advances by one after each instruction fetch
// - true skip discards prefetched word, dummy cycle, counter net plus two
// - jump, call, return, vector, low-byte write load counter; two cycles
// - reset clears the counter so execution starts at address zero
// - interrupt vectors: external 004, timer 008, converter 00c
// - counter low byte at 06; write replaces low eight bits only
// - program memory of 15-bit words, addressed by counter or table pointer
// - current-page table read keeps upper counter bits; last page forces ones
// - table read: low byte to data memory, high bits to 08; pointer at 07
// - every table read takes two instruction cycles
// - six-entry return stack, invisible to software
// - call and interrupt push the counter; returns pop it
// - reset leaves the stack empty
// - stack full: interrupt held off until a return pops
// - call on full stack overwrites the oldest entry
// - data addresses below 28 not decoded here read the outside special registers
// - small variant general memory spans 28 to e7
// - bit updates reach any byte; pointers at 01 and 03 give indirection
// - large variant: bank selector 01 sends pointer-one 40..7f to bank 1
// - addresses 00 and 02 act on the byte under pointer zero or one
module msq_program_sequencer #(
  parameter LARGE_VARIANT = 1
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // phase clocks
  output reg [3:0] phase_q,
  // program memory
  output reg [11:0] rom_addr_q,
  input wire [14:0] rom_data,
  // instruction to execute unit
  output reg [14:0] instr_q,
  output reg instr_valid_q,
  // execute unit requests, sampled in the last phase
  input wire ex_skip,
  input wire ex_jump,
  input wire ex_call,
  input wire ex_ret,
  input wire [11:0] ex_target,
  input wire ex_tbl_cur,
  input wire ex_tbl_last,
  input wire [7:0] ex_tbl_dst,
  // data memory access from execute unit
  input wire [7:0] dm_addr,
  input wire dm_wr,
  input wire [7:0] dm_wdata,
  output reg [7:0] dm_rdata,
  // data ram array
  output reg [8:0] ram_addr,
  output reg ram_we,
  output reg [7:0] ram_wdata,
  input wire [7:0] ram_rdata,
  // other special registers, outside this block
  output reg [7:0] sfr_addr,
  output reg sfr_we,
  output reg [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  // interrupt controller: 0 external, 1 timer, 2 converter
  input wire [2:0] irq_req,
  output reg [2:0] irq_ack_q,
  output wire stack_full
);

  localparam [11:0] PC_MASK = LARGE_VARIANT ? `MSQ_PC_MASK_L :
    `MSQ_PC_MASK_S;
  localparam [7:0] RAM_HI = LARGE_VARIANT ? 8'hff : `MSQ_RAM_HI_S;

  // address classes
  localparam [2:0] C_ZERO = 3'h0;
  localparam [2:0] C_RAM = 3'h1;
  localparam [2:0] C_SFR = 3'h2;
  localparam [2:0] C_OWN = 3'h3;

  reg [11:0] pc_q;
  reg [11:0] pc_d;
  reg [11:0] exec_pc_q;
  reg [7:0] ptr0_q;
  reg [7:0] ptr1_q;
  reg [7:0] bank_q;
  reg [7:0] table_pointer_q;
  reg [6:0] table_high_result_q;
  reg tbl_q;
  reg [7:0] tbl_dst_q;
  reg [11:0] stk [0:5];
  reg [2:0] head_q;
  reg [2:0] count_q;

  wire ph_last = phase_q[3];
  wire ctl_go = instr_valid_q & ph_last;
  wire tbl_fin = ph_last & tbl_q;
  wire [2:0] head_up = (head_q == `MSQ_STK_LAST) ? 3'h0 : head_q + 3'h1;
  wire [2:0] head_dn = (head_q == 3'h0) ? `MSQ_STK_LAST : head_q - 3'h1;
  wire [11:0] pc_inc = (pc_q + 12'h001) & PC_MASK;
  wire [11:0] tbl_addr = {(ex_tbl_last ? 4'hf : pc_q[11:8]), table_pointer_q}
    & PC_MASK;
  wire irq_any = |irq_req;
  wire [11:0] irq_vec = irq_req[0] ? `MSQ_VEC_EXT :
    irq_req[1] ? `MSQ_VEC_TMR : `MSQ_VEC_ADC;

  assign stack_full = (count_q == `MSQ_STK_DEPTH);

  // ****************************************
  // data address resolution
  // ****************************************
  // returns {bank bit, effective byte address}
  function [8:0] msq_resolve;
    input [7:0] a;
    input [7:0] p0;
    input [7:0] p1;
    input [7:0] bk;
    begin
      if (a == `MSQ_ADR_IND0)
        msq_resolve = {1'b0, p0};
      else if (a == `MSQ_ADR_IND1)
        msq_resolve = {(LARGE_VARIANT != 0) && (bk == `MSQ_BANK_ONE)
          && (p1 >= `MSQ_B1_LO) && (p1 <= `MSQ_B1_HI), p1};
      else
        msq_resolve = {1'b0, a};
    end
  endfunction

  function [2:0] msq_class;
    input [8:0] e;
    begin
      if (e[7:0] == `MSQ_ADR_IND0 || e[7:0] == `MSQ_ADR_IND1)
        msq_class = C_ZERO;
      else if (e[7:0] == `MSQ_ADR_PTR0 || e[7:0] == `MSQ_ADR_PTR1
        || e[7:0] == `MSQ_ADR_PCL || e[7:0] == `MSQ_ADR_TABLE_POINTER
        || e[7:0] == `MSQ_ADR_TABLE_HIGH_RESULT
        || (e[7:0] == `MSQ_ADR_BANK && LARGE_VARIANT != 0))
        msq_class = C_OWN;
      else if (e[7:0] < `MSQ_RAM_LO)
        msq_class = C_SFR;
      else if (e[7:0] <= RAM_HI)
        msq_class = C_RAM;
      else
        msq_class = C_ZERO;
    end
  endfunction

  wire [7:0] wr_raw = tbl_fin ? tbl_dst_q : dm_addr;
  wire [8:0] wr_ea = msq_resolve(wr_raw, ptr0_q, ptr1_q, bank_q);
  wire [8:0] rd_ea = msq_resolve(dm_addr, ptr0_q, ptr1_q, bank_q);
  wire [2:0] wr_cls = msq_class(wr_ea);
  wire [2:0] rd_cls = msq_class(rd_ea);
  // table read borrows the write path in its second cycle
  wire wr_en = tbl_fin | (ctl_go & dm_wr);
  wire [7:0] wr_data = tbl_fin ? rom_data[7:0] : dm_wdata;
  wire own_wr = wr_en & (wr_cls == C_OWN);
  wire pcl_wr = ctl_go & dm_wr & (wr_cls == C_OWN)
    & (wr_ea[7:0] == `MSQ_ADR_PCL) & ~tbl_q;
  wire irq_go = ph_last & irq_any & ~stack_full & ~tbl_q & ~(instr_valid_q
    & (ex_skip | ex_jump | ex_call | ex_ret | ex_tbl_cur | ex_tbl_last
    | pcl_wr));

  // ****************************************
  // data read and write steering
  // ****************************************
  always @*
  begin
    ram_addr = rd_ea;
    ram_we = 1'b0;
    ram_wdata = wr_data;
    sfr_addr = rd_ea[7:0];
    sfr_we = 1'b0;
    sfr_wdata = wr_data;
    if (wr_en)
    begin
      ram_addr = wr_ea;
      sfr_addr = wr_ea[7:0];
      ram_we = (wr_cls == C_RAM);
      sfr_we = (wr_cls == C_SFR);
    end
    case (rd_cls)
      C_RAM: dm_rdata = ram_rdata;
      C_SFR: dm_rdata = sfr_rdata;
      C_OWN:
        case (rd_ea[7:0])
          `MSQ_ADR_PTR0: dm_rdata = ptr0_q;
          `MSQ_ADR_PTR1: dm_rdata = ptr1_q;
          `MSQ_ADR_BANK: dm_rdata = bank_q;
          `MSQ_ADR_PCL: dm_rdata = exec_pc_q[7:0];
          `MSQ_ADR_TABLE_POINTER: dm_rdata = table_pointer_q;
          `MSQ_ADR_TABLE_HIGH_RESULT: dm_rdata = {1'b0, table_high_result_q};
          default: dm_rdata = `MSQ_RST_BYTE;
        endcase
      default: dm_rdata = `MSQ_RST_BYTE;
    endcase
  end

  // ****************************************
  // phase generator
  // ****************************************
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      phase_q <= `MSQ_PH_FIRST;
    else
      phase_q <= {phase_q[2:0], phase_q[3]};
  end

  // ****************************************
  // own special registers
  // ****************************************
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ptr0_q <= `MSQ_RST_BYTE;
      ptr1_q <= `MSQ_RST_BYTE;
      bank_q <= `MSQ_RST_BYTE;
      table_pointer_q <= `MSQ_RST_BYTE;
      table_high_result_q <= 7'h00;
    end
    else
    begin
      if (own_wr && wr_ea[7:0] == `MSQ_ADR_PTR0)
        ptr0_q <= wr_data;
      if (own_wr && wr_ea[7:0] == `MSQ_ADR_PTR1)
        ptr1_q <= wr_data;
      if (own_wr && wr_ea[7:0] == `MSQ_ADR_BANK)
        bank_q <= wr_data;
      if (own_wr && wr_ea[7:0] == `MSQ_ADR_TABLE_POINTER)
        table_pointer_q <= wr_data;
      // high byte has no write path: read only
      if (tbl_fin)
        table_high_result_q <= rom_data[14:8];
    end
  end

  // ****************************************
  // program counter and pipeline
  // ****************************************
  always @*
  begin
    pc_d = pc_inc;
    if (tbl_q)
      pc_d = pc_q;
    else if (instr_valid_q && ex_skip)
      pc_d = pc_inc;
    else if (instr_valid_q && (ex_jump || ex_call))
      pc_d = ex_target & PC_MASK;
    else if (instr_valid_q && ex_ret)
      pc_d = stk[head_q];
    else if (pcl_wr)
      pc_d = {pc_q[11:8], wr_data};
    else if (irq_go)
      pc_d = irq_vec;
  end

  wire flush = ~tbl_q & (irq_go | (instr_valid_q & (ex_skip | ex_jump
    | ex_call | ex_ret)) | pcl_wr);
  wire tbl_start = ~flush & ~tbl_q & instr_valid_q
    & (ex_tbl_cur | ex_tbl_last);

  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      pc_q <= `MSQ_VEC_RESET;
      rom_addr_q <= `MSQ_VEC_RESET;
      exec_pc_q <= `MSQ_VEC_RESET;
      instr_q <= 15'h0000;
      instr_valid_q <= 1'b0;
      tbl_q <= 1'b0;
      tbl_dst_q <= `MSQ_RST_BYTE;
      irq_ack_q <= 3'h0;
    end
    else
    begin
      irq_ack_q <= 3'h0;
      if (ph_last)
      begin
        pc_q <= pc_d;
        rom_addr_q <= tbl_start ? tbl_addr : pc_d;
        if (tbl_q)
        begin
          // held word runs now; table word was the dummy fetch
          tbl_q <= 1'b0;
          instr_valid_q <= 1'b1;
        end
        else if (flush)
          instr_valid_q <= 1'b0;
        else
        begin
          instr_q <= rom_data;
          exec_pc_q <= pc_q;
          instr_valid_q <= ~tbl_start;
          tbl_q <= tbl_start;
          tbl_dst_q <= ex_tbl_dst;
        end
        if (irq_go && !(instr_valid_q && ex_skip))
          irq_ack_q <= irq_req[0] ? 3'h1 : irq_req[1] ? 3'h2 : 3'h4;
      end
    end
  end

  // ****************************************
  // return stack
  // ****************************************
  // ring of six: a push on full drops the oldest without a shift
  wire do_push = ph_last & ~tbl_q & ((instr_valid_q & ex_call & ~ex_skip
    & ~ex_jump) | (irq_go & ~(instr_valid_q & ex_skip)));
  wire do_pop = ph_last & ~tbl_q & instr_valid_q & ex_ret & ~ex_skip
    & ~ex_jump & ~ex_call;

  always @(posedge clk_sys)
  begin
    if (do_push)
      stk[head_up] <= pc_q;
  end

  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      head_q <= `MSQ_STK_LAST;
      count_q <= 3'h0;
    end
    else if (do_push)
    begin
      head_q <= head_up;
      if (!stack_full)
        count_q <= count_q + 3'h1;
    end
    else if (do_pop && count_q != 3'h0)
    begin
      head_q <= head_dn;
      count_q <= count_q - 3'h1;
    end
  end

endmodule // msq_program_sequencer

// ==== testbench/msq_mem_model.sv ====
// program rom and data ram model behind the sequencer
module msq_mem_model (
  // clock
  input wire logic clk_sys,
  // program memory
  input wire logic [11:0] rom_addr_q,
  output logic [14:0] rom_data,
  // data ram array
  input wire logic [8:0] ram_addr,
  input wire logic ram_we,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [0:511];
  // each word carries its own address so every fetch can be traced
  assign rom_data = {3'h5, rom_addr_q};
  assign ram_rdata = mem_q[ram_addr];
  always @(posedge clk_sys)
  begin
    if (ram_we)
    begin
      mem_q[ram_addr] <= ram_wdata;
    end
  end
endmodule // msq_mem_model

// ==== testbench/msq_seq_assertions.sv ====
// port checker for the program sequencer
module msq_seq_assertions (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // sequencing and requests
  input wire [3:0] phase_q,
  input wire [11:0] rom_addr_q,
  input wire instr_valid_q,
  input wire ex_skip,
  input wire ex_jump,
  input wire ex_call,
  input wire ex_ret,
  input wire [11:0] ex_target,
  input wire ex_tbl_cur,
  input wire ex_tbl_last,
  input wire [7:0] dm_addr,
  input wire dm_wr,
  input wire [8:0] ram_addr,
  input wire [2:0] irq_req,
  input wire [2:0] irq_ack_q,
  input wire stack_full
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire bnd = phase_q[3] && instr_valid_q;
  // a low-byte write is a control transfer too
  wire ctl = ex_skip || ex_jump || ex_call || ex_ret ||
    (dm_wr && dm_addr == 8'h06);
  wire calm = bnd && !ctl && irq_req == 3'h0;
  phase_walk_a: assert property (phase_q[0] |=> phase_q[1] ##1
    phase_q[2] ##1 phase_q[3] ##1 phase_q[0]) else $error("phase order");
  phase_hot_a: assert property ($onehot(phase_q))
    else $error("phase not one-hot");
  fetch_inc_a: assert property (calm && !ex_tbl_cur && !ex_tbl_last
    |=> rom_addr_q == $past(rom_addr_q) + 12'h1) else $error("no advance");
  skip_dummy_a: assert property (bnd && ex_skip |=> !instr_valid_q &&
    rom_addr_q == $past(rom_addr_q) + 12'h1) else $error("bad skip");
  jump_load_a: assert property (bnd && ex_jump && !ex_skip |=>
    !instr_valid_q && rom_addr_q == $past(ex_target)) else $error("bad jump");
  irq_vec_a: assert property (bnd && !ctl && irq_req[0] && !stack_full
    && !ex_tbl_cur && !ex_tbl_last |=> rom_addr_q == 12'h004 ##[0:1]
    irq_ack_q == 3'h1) else $error("vec");
  irq_hold_a: assert property (phase_q[3] && stack_full &&
    !(instr_valid_q && ex_ret) |=> (irq_ack_q == 3'h0) [*2])
    else $error("ack on full stack");
  tbl_last_a: assert property (calm && ex_tbl_last |=>
    !instr_valid_q && rom_addr_q[11:8] == 4'hf ##4 instr_valid_q)
    else $error("bad table read");
  // second table cycle borrows the port for its own destination
  bank_direct_a: assert property (dm_addr >= 8'h28 &&
    !(phase_q[3] && !instr_valid_q) |-> ram_addr == {1'b0, dm_addr})
    else $error("direct not bank 0");
  reset_pc_a: assert property (disable iff (1'b0) !rst_b |=>
    rom_addr_q == 12'h000 && !instr_valid_q) else $error("reset pc");
  cover property (bnd && ex_call && stack_full);
  cover property (irq_ack_q != 3'h0);
  cover property (calm && ex_tbl_last);
endmodule // msq_seq_assertions

bind msq_program_sequencer msq_seq_assertions chk (.clk_sys(clk_sys),
  .rst_b(rst_b), .phase_q(phase_q), .rom_addr_q(rom_addr_q),
  .instr_valid_q(instr_valid_q), .ex_skip(ex_skip), .ex_jump(ex_jump),
  .ex_call(ex_call), .ex_ret(ex_ret), .ex_target(ex_target),
  .ex_tbl_cur(ex_tbl_cur), .ex_tbl_last(ex_tbl_last), .dm_addr(dm_addr),
  .dm_wr(dm_wr), .ram_addr(ram_addr), .irq_req(irq_req),
  .irq_ack_q(irq_ack_q), .stack_full(stack_full));

// ==== testbench/tb_mcu_program_sequencer.sv ====
// self-checking bench for the program sequencer
module tb_mcu_program_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_b, instr_valid_q, ex_skip, ex_jump, ex_call, ex_ret;
  logic ex_tbl_cur, ex_tbl_last, dm_wr, ram_we, sfr_we, stack_full;
  logic [3:0] phase_q;
  logic [11:0] rom_addr_q, ex_target, fa;
  logic [14:0] rom_data, instr_q;
  logic [7:0] ex_tbl_dst, dm_addr, dm_wdata, dm_rdata, ram_wdata, ram_rdata;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [15:0] sfr_seen;
  logic [8:0] ram_addr;
  logic [2:0] irq_req, irq_ack_q;
  logic [11:0] ra [1:7];
  int fails, cmp_count;
  msq_program_sequencer dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .phase_q(phase_q), .rom_addr_q(rom_addr_q), .rom_data(rom_data),
    .instr_q(instr_q), .instr_valid_q(instr_valid_q), .ex_skip(ex_skip),
    .ex_jump(ex_jump), .ex_call(ex_call), .ex_ret(ex_ret),
    .ex_target(ex_target), .ex_tbl_cur(ex_tbl_cur),
    .ex_tbl_last(ex_tbl_last), .ex_tbl_dst(ex_tbl_dst), .dm_addr(dm_addr),
    .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
    .ram_addr(ram_addr), .ram_we(ram_we), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_req(irq_req),
    .irq_ack_q(irq_ack_q), .stack_full(stack_full));
  msq_mem_model mem (.clk_sys(clk_sys), .rom_addr_q(rom_addr_q),
    .rom_data(rom_data), .ram_addr(ram_addr), .ram_we(ram_we),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
  // low addresses answer non-zero so a missed local decode shows up
  assign sfr_rdata = (sfr_addr < 8'h20) ? 8'h4b : 8'h00;
  always @(posedge clk_sys)
  begin
    if (sfr_we)
    begin
      sfr_seen <= {sfr_addr, sfr_wdata};
    end
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // returns at the falling edge in the cycle before a live boundary
  task automatic slot();
    int n;
    n = 0;
    @(negedge clk_sys);
    while (!(phase_q[2] === 1'b1 && instr_valid_q === 1'b1) && n < 64)
    begin
      @(negedge clk_sys);
      n++;
    end
    fa = rom_addr_q;
  endtask
  task automatic issue(input logic [6:0] k, input logic [11:0] t);
    slot();
    @(posedge clk_sys);
    {dm_wr, ex_tbl_last, ex_tbl_cur, ex_ret, ex_call, ex_jump, ex_skip} <= k;
    ex_target <= t;
    @(posedge clk_sys);
    {dm_wr, ex_tbl_last, ex_tbl_cur, ex_ret, ex_call, ex_jump, ex_skip} <= '0;
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    dm_addr <= a;
    dm_wdata <= d;
    issue(7'h40, 12'h0);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    dm_addr <= a;
    @(negedge clk_sys);
    chk(dm_rdata, e);
  endtask
  task automatic wrap_up();
    if (fails == 0 && cmp_count > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_flow();
    slot();
    chk(instr_q, 15'h5000);
    slot();
    chk(instr_q, 15'h5001);
    issue(7'h02, 12'h9a5);
    slot();
    chk(instr_q, 15'h59a5);
    // skip while 9a6 executes drops the prefetched 9a7
    issue(7'h01, 12'h0);
    slot();
    chk(instr_q, 15'h59a8);
    wr(8'h06, 8'h5a);
    chk(rom_addr_q, {fa[11:8], 8'h5a});
  endtask
  task automatic t_stack();
    for (int i = 1; i <= 7; i++)
    begin
      issue(7'h04, 12'h100 + 12'(16 * i));
      ra[i] = fa;
      if (i == 5)
      begin
        chk(stack_full, 1'b0);
      end
    end
    chk(stack_full, 1'b1);
    @(posedge clk_sys);
    irq_req <= 3'h1;
    repeat (12) @(posedge clk_sys);
    irq_req <= 3'h0;
    chk(rom_addr_q[11:8], 4'h1);
    for (int i = 7; i >= 2; i--)
    begin
      issue(7'h08, 12'h0);
      chk(rom_addr_q, ra[i]);
    end
  endtask
  task automatic t_irq();
    int n;
    for (int v = 0; v < 3; v++)
    begin
      // raise it in a live cycle so the boundary has a real instruction
      slot();
      @(posedge clk_sys);
      irq_req <= 3'h1 << v;
      n = 0;
      while (irq_ack_q === 3'h0 && n < 40)
      begin
        @(negedge clk_sys);
        n++;
      end
      chk({irq_ack_q, rom_addr_q}, {3'h1 << v, 12'(4 * (v + 1))});
      @(posedge clk_sys);
      irq_req <= 3'h0;
      issue(7'h08, 12'h0);
    end
  endtask
  task automatic t_data();
    wr(8'h07, 8'h3c);
    @(posedge clk_sys);
    ex_tbl_dst <= 8'h30;
    issue(7'h20, 12'h0);
    slot();
    rdchk(8'h08, 8'h5f);
    rdchk(8'h30, 8'h3c);
    wr(8'h08, 8'hff);
    rdchk(8'h08, 8'h5f);
    wr(8'h45, 8'h11);
    wr(8'h03, 8'h45);
    wr(8'h04, 8'h01);
    wr(8'h02, 8'ha7);
    rdchk(8'h02, 8'ha7);
    rdchk(8'h45, 8'h11);
    rdchk(8'h20, 8'h00);
    rdchk(8'h00, 8'h00);
    rdchk(8'h0a, 8'h4b);
    wr(8'h0a, 8'h77);
    chk(sfr_seen, 16'h0a77);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst_b = 1'b0;
    {dm_wr, ex_tbl_last, ex_tbl_cur, ex_ret, ex_call, ex_jump, ex_skip} = '0;
    ex_target = 12'h0;
    ex_tbl_dst = 8'h0;
    dm_addr = 8'h0;
    dm_wdata = 8'h0;
    irq_req = 3'h0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_flow();
    t_stack();
    t_irq();
    t_data();
    wrap_up();
  end
  // whole run is a few hundred clocks; this cuts a hang
  initial
  begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule // tb_mcu_program_sequencer
